// ---- design/prescaler_pkg.sv ----
package prescaler_pkg;

	// ----------------------------------------------------------------
	// Moduli
	// ----------------------------------------------------------------
	localparam int          CNT_W        = 8;
	localparam logic [7:0]  LOW_PAIR_DIV = 8'h40;
	localparam logic [7:0]  HIGH_PAIR_DIV = 8'h80;

	// ----------------------------------------------------------------
	// Output variants
	// ----------------------------------------------------------------
	localparam logic        EDGE_RISE    = 1'h1;
	localparam logic        EDGE_FALL    = 1'h0;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  CNT_RST      = 8'h00;
	localparam logic [7:0]  MOD_RST      = 8'h81;
	localparam int          CLK_MHZ      = 50;
	localparam int          SETUP_NS     = 10;
	localparam int          SETUP_CYC    = (SETUP_NS * CLK_MHZ) / 1000 < 1 ?
	                                       1 : (SETUP_NS * CLK_MHZ) / 1000;

	typedef enum logic [0:0] {
		PH_MARK  = 1'b0,
		PH_SPACE = 1'b1
	} phase_t;

	function automatic logic [7:0] pick_modulus(input logic range_hi,
	                                            input logic pick_low);
		logic [7:0] base;
		base = range_hi ? LOW_PAIR_DIV : HIGH_PAIR_DIV;
		return pick_low ? base : 8'(base + 8'h01);
	endfunction

endpackage

// ---- design/edge_shaper.sv ----
`timescale 1ns/1ns
module edge_shaper
	import prescaler_pkg::*;
#(
	parameter logic EDGE_POL = EDGE_RISE
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic boundary,
	output logic      div_out
);

	logic active_r;

	// Active level lasts the one cycle after each boundary; the trigger edge comes one clock after boundary
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_r <= 1'b0;
		end else begin
			active_r <= boundary;
		end
	end

	// Rising-edge part idles low, falling-edge part idles high
	assign div_out = (EDGE_POL == EDGE_RISE) ? active_r : ~active_r;

	cov_edge: cover property (@(posedge clk) disable iff (!rst_n)
		$changed(div_out));

endmodule

// ---- design/dual_modulus_prescaler.sv ----
`timescale 1ns/1ns
// Overview of operation
// - A high range select chooses the 64/65 pair, low chooses 128/129.
// - High modulus pick divides by the lower value, low by the higher.
// - The rising-edge variant marks each output period with a rise.
// - The falling-edge variant marks each output period with a fall.
module dual_modulus_prescaler
	import prescaler_pkg::*;
#(
	parameter logic EDGE_POL = EDGE_RISE
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ratio_range_select,
	input  wire logic modulus_pick,
	output logic      div_out,
	output logic      period_start
);

	// ----------------------------------------------------------------
	// Cycle counter
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] modulus_r;
	logic [CNT_W-1:0] modulus_nxt;
	logic [CNT_W-1:0] next_mod;
	logic             last_w;

	// Modulus is sampled only at the boundary, so a mid-period change
	// never shortens the period in progress.
	assign next_mod    = pick_modulus(ratio_range_select, modulus_pick);
	assign last_w      = (cnt_r == CNT_W'(modulus_r - 8'h01));
	assign cnt_nxt     = last_w ? CNT_RST : CNT_W'(cnt_r + 8'h01);
	assign modulus_nxt = last_w ? next_mod : modulus_r;
	assign period_start = last_w;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Reset starts from the largest modulus; the first boundary loads
	// whatever the inputs then ask for.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modulus_r <= MOD_RST;
		end else begin
			modulus_r <= modulus_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Output shaping
	// ----------------------------------------------------------------
	edge_shaper #(
		.EDGE_POL (EDGE_POL)
	) u_shaper (
		.clk      (clk),
		.rst_n    (rst_n),
		.boundary (last_w),
		.div_out  (div_out)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [CNT_W:0] gap_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_r <= '0;
		end else begin
			gap_r <= last_w ? '0 : (CNT_W+1)'(gap_r + 9'h001);
		end
	end

	// Copies of the inputs as they stood at the boundary edge
	logic ratio_range_select_q;
	logic modulus_pick_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ratio_range_select_q <= 1'b0;
			modulus_pick_q       <= 1'b0;
		end else begin
			ratio_range_select_q <= ratio_range_select;
			modulus_pick_q       <= modulus_pick;
		end
	end

	pair_select_a: assert property (@(posedge clk) disable iff (!rst_n)
		last_w |=> (ratio_range_select_q ? modulus_r[6] : modulus_r[7]))
		else $error("modulus outside selected pair");

	// ----------------------------------------------------------------
	// Ratio table checks
	// ----------------------------------------------------------------
	// Each corner of the ratio table is checked against the constants,
	// so a slip in the selection function cannot hide behind itself.
	div64_a: assert property (@(posedge clk) disable iff (!rst_n)
		(last_w && ratio_range_select && modulus_pick)
		|=> (modulus_r == LOW_PAIR_DIV))
		else $error("high range with high pick did not give 64");

	div65_a: assert property (@(posedge clk) disable iff (!rst_n)
		(last_w && ratio_range_select && !modulus_pick)
		|=> (modulus_r == CNT_W'(LOW_PAIR_DIV + 8'h01)))
		else $error("high range with low pick did not give 65");

	div128_a: assert property (@(posedge clk) disable iff (!rst_n)
		(last_w && !ratio_range_select && modulus_pick)
		|=> (modulus_r == HIGH_PAIR_DIV))
		else $error("low range with high pick did not give 128");

	div129_a: assert property (@(posedge clk) disable iff (!rst_n)
		(last_w && !ratio_range_select && !modulus_pick)
		|=> (modulus_r == CNT_W'(HIGH_PAIR_DIV + 8'h01)))
		else $error("low range with low pick did not give 129");

	// ----------------------------------------------------------------
	// Counter progress checks
	// ----------------------------------------------------------------
	cnt_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		last_w |=> (cnt_r == CNT_RST))
		else $error("counter did not restart at boundary");

	cnt_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		!last_w |=> (cnt_r == CNT_W'($past(cnt_r) + 8'h01)))
		else $error("counter skipped or stalled");

	// ----------------------------------------------------------------
	// Output idle checks
	// ----------------------------------------------------------------
	// Outside the one cycle after a boundary the output sits at its
	// idle level, so only one trigger edge reaches the synthesizer.
	idle_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
		(EDGE_POL == EDGE_RISE && !$past(last_w)) |-> (div_out == 1'b0))
		else $error("rising variant left its idle level");

	idle_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
		(EDGE_POL == EDGE_FALL && !$past(last_w)) |-> (div_out == 1'b1))
		else $error("falling variant left its idle level");

	pick_value_a: assert property (@(posedge clk) disable iff (!rst_n)
		last_w |=> (modulus_r[0] == !modulus_pick_q))
		else $error("modulus pick gave wrong ratio");

	period_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		(last_w && $past(last_w) == 1'b0 && gap_r != '0)
		|-> (gap_r == (CNT_W+1)'(modulus_r - 8'h01)))
		else $error("period length differs from modulus");

	hold_mod_a: assert property (@(posedge clk) disable iff (!rst_n)
		!last_w |=> $stable(modulus_r))
		else $error("modulus changed mid period");

	rise_mark_a: assert property (@(posedge clk) disable iff (!rst_n)
		(EDGE_POL == EDGE_RISE && last_w) |=> $rose(div_out) ##1 $fell(div_out))
		else $error("rising variant missed its edge");

	fall_mark_a: assert property (@(posedge clk) disable iff (!rst_n)
		(EDGE_POL == EDGE_FALL && last_w) |=> $fell(div_out) ##1 $rose(div_out))
		else $error("falling variant missed its edge");

	cnt_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		cnt_r < modulus_r)
		else $error("counter beyond modulus");

	one_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
		last_w |=> !last_w)
		else $error("two boundaries back to back");

	cov_div64: cover property (@(posedge clk) disable iff (!rst_n)
		last_w && modulus_r == 8'h40);
	cov_div65: cover property (@(posedge clk) disable iff (!rst_n)
		last_w && modulus_r == 8'h41);
	cov_div128: cover property (@(posedge clk) disable iff (!rst_n)
		last_w && modulus_r == 8'h80);
	cov_div129: cover property (@(posedge clk) disable iff (!rst_n)
		last_w && modulus_r == 8'h81);

endmodule

// ---- sim/synth_model.sv ----
`timescale 1ns/1ns
module synth_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic trig,
	output logic      pick
);
	logic [2:0] c_r;
	logic       t_r;
	// Swallow count: 3 of every 5 periods use N+1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c_r <= 3'h0;
			t_r <= 1'b0;
		end else begin
			t_r <= trig;
			if (trig && !t_r)
				c_r <= (c_r == 3'h4) ? 3'h0 : c_r + 3'h1;
		end
	end
	assign pick = (c_r > 3'h2);
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	logic        clk, rst_n, rng, tpk, use_m, mpk, ro, fo, ps;
	logic [15:0] n;
	int          err_count, checks_done;
	wire         pk = use_m ? mpk : tpk;
	dual_modulus_prescaler #(.EDGE_POL(1'h1)) dut (.clk(clk), .rst_n(rst_n),
		.ratio_range_select(rng), .modulus_pick(pk), .div_out(ro),
		.period_start(ps));
	dual_modulus_prescaler #(.EDGE_POL(1'h0)) dut_fall (.clk(clk),
		.rst_n(rst_n), .ratio_range_select(rng), .modulus_pick(pk),
		.div_out(fo), .period_start());
	synth_model synth (.clk(clk), .rst_n(rst_n), .trig(ro), .pick(mpk));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic conclude();
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	// Counts to the next boundary; e also checks the trigger pulse
	task automatic meas(input logic [15:0] s, input logic e);
		n = s;
		do begin
			@(posedge clk);
			n++;
			if (e && n < 16'h0003)
				chk({14'h0000, ro, fo}, 16'h0003 - n);
		end while (ps !== 1'b1 && n < 16'h0200);
		if (n == 16'h0200) begin
			err_count++;
			conclude();
		end
	endtask
	task automatic rst_cycle();
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk({13'h0000, ro, fo, ps}, 16'h0002);
		rst_n <= 1'b1;
		meas(16'h0000, 1'b0);
	endtask
	// Each change is set on a boundary, so it must land one period late
	task automatic walk();
		logic [15:0] p;
		p = 16'h0081;
		for (int i = 0; i < 5; i++) begin
			rng <= i[1];
			tpk <= i[0];
			meas(16'h0000, 1'b1);
			chk(n, p);
			p = (i[1] ? 16'h0040 : 16'h0080) + {15'h0000, !i[0]};
		end
	endtask
	task automatic glitch();
		repeat (10) @(posedge clk);
		tpk <= 1'b1;
		repeat (10) @(posedge clk);
		tpk <= 1'b0;
		meas(16'h0014, 1'b0);
		chk(n, 16'h0081);
	endtask
	task automatic frame();
		logic [15:0] t;
		rng <= 1'b1;
		use_m <= 1'b1;
		meas(16'h0000, 1'b0);
		t = 16'h0000;
		repeat (5) begin
			meas(16'h0000, 1'b1);
			t += n;
		end
		chk(t, 16'h0143);
		use_m <= 1'b0;
		tpk <= 1'b1;
	endtask
	initial begin
		rst_n = 1'b0;
		rng = 1'b0;
		tpk = 1'b0;
		use_m = 1'b0;
		err_count = 0;
		checks_done = 0;
		rst_cycle();
		walk();
		glitch();
		frame();
		repeat (30) @(posedge clk);
		rst_cycle();
		meas(16'h0000, 1'b1);
		chk(n, 16'h0040);
		conclude();
	end
endmodule
